// ### pkg/spio_defines.vh
// constants for the shared pin io port: register map, fields, option codes
`ifndef SPIO_DEFINES_VH
`define SPIO_DEFINES_VH
`define SPIO_ADDR_W      12
`define SPIO_OFF_DATA    12'h000
`define SPIO_OFF_DIR     12'h004
`define SPIO_OFF_PULL    12'h008
`define SPIO_OFF_WAKE    12'h00C
`define SPIO_OFF_CFG     12'h010
`define SPIO_OFF_PIN     12'h014
`define SPIO_OFF_STAT    12'h018
`define SPIO_RST_DATA    7'h00
`define SPIO_RST_DIR     7'h7F
`define SPIO_RST_PULL    7'h00
`define SPIO_RST_WAKE    5'h00
`define SPIO_RST_CFG     6'h00
`define SPIO_CFG_OSC_LO  0
`define SPIO_CFG_OSC_HI  1
`define SPIO_CFG_FRQ_LO  2
`define SPIO_CFG_FRQ_HI  3
`define SPIO_CFG_RESPIN  4
`define SPIO_CFG_BUZEN   5
`define SPIO_OSC_INT_RC  2'h0
`define SPIO_OSC_XTAL    2'h1
`define SPIO_OSC_RC_RTC  2'h2
`define SPIO_OSC_EXT_RC  2'h3
`define SPIO_FRQ_4M      2'h0
`define SPIO_FRQ_8M      2'h1
`define SPIO_FRQ_12M     2'h2
`define SPIO_BIT_OSC_OUT 5
`define SPIO_BIT_OSC_IN  6
`define SPIO_BIT_CNT_A   2
`define SPIO_BIT_EXTINT  3
`define SPIO_BIT_CNT_B   4
`define SPIO_GEN_LINES   5
`define SPIO_BIDIR       7
`define SPIO_LINES       8
`define SPIO_SYNC_W      3
`endif

// ### hdl/spio_port.v
// shared pin io port: seven bidirectional lines, one input line, apb registers
// Summary of operation
// [RQ1] seven bidirectional lines plus one input-only line
// [RQ2] per-pin direction: push-pull output or input
// [RQ3] five general lines individually enabled for wake-up
// [RQ4] per-pin pull-high enable bit
// [RQ5] lines 0 and 1 carry complementary buzzer pair
// [RQ6] line 2 feeds counter a external input
// [RQ7] line 4 feeds counter b external input
// [RQ8] line 3 is active-low external interrupt input
// [RQ9] internal rc option: both oscillator pins are io
// [RQ10] crystal option: both oscillator pins dedicated
// [RQ11] rc plus rtc option: pins serve 32768 hz crystal
// [RQ12] external rc: line 6 oscillator input, line 5 io
// [RQ13] internal rc frequency select: 4, 8, 12 mhz
// [RQ14] line 7 is chip reset or input
// [RQ15] dedicated pins ignore settings, read zero
`timescale 1ns/1ns
`include "spio_defines.vh"
module spio_port (
	// clock and reset
	input  wire                    clock_in,
	input  wire                    arst_n_in,
	// apb slave
	input  wire                    psel_in,
	input  wire                    penable_in,
	input  wire                    pwrite_in,
	input  wire [`SPIO_ADDR_W-1:0] paddr_in,
	input  wire [31:0]             pwdata_in,
	input  wire [3:0]              pstrb_in,
	output wire                    pready_out,
	output wire                    pslverr_out,
	output reg  [31:0]             prdata_out,
	// pins, output enable active low
	input  wire [`SPIO_LINES-1:0]  pin_in,
	output reg  [`SPIO_BIDIR-1:0]  pin_out,
	output reg  [`SPIO_BIDIR-1:0]  pin_oe_n_out,
	output reg  [`SPIO_BIDIR-1:0]  pin_pull_en_out,
	// shared functions
	input  wire                    buzzer_drive_true_in,
	output reg                     counter_a_ext_input_out,
	output reg                     counter_b_ext_input_out,
	output reg                     ext_irq_n_out,
	output reg                     chip_reset_n_out,
	output reg                     wake_out,
	// oscillator configuration
	output reg  [1:0]              osc_mode_out,
	output reg  [1:0]              rc_freq_sel_out,
	output reg                     rtc_xtal_en_out
);

	reg  [`SPIO_BIDIR-1:0]   data_q;
	reg  [`SPIO_BIDIR-1:0]   dir_q;
	reg  [`SPIO_BIDIR-1:0]   pull_q;
	reg  [`SPIO_GEN_LINES-1:0] wake_q;
	reg  [5:0]               cfg_q;
	reg  [`SPIO_LINES-1:0]   s1_q;
	reg  [`SPIO_LINES-1:0]   s2_q;
	reg  [`SPIO_LINES-1:0]   s3_q;
	reg  [`SPIO_LINES-1:0]   clean_q;
	reg  [`SPIO_LINES-1:0]   last_q;
	reg  [`SPIO_LINES-1:0]   ded;
	reg  [`SPIO_LINES-1:0]   rd_pins;
	reg  [31:0]              rdata_d;
	reg                      hit;
	reg                      rd_wait_q;
	wire [1:0]               osc_mode;
	wire                     wr_en;
	wire                     rd_en;

	assign osc_mode = cfg_q[`SPIO_CFG_OSC_HI:`SPIO_CFG_OSC_LO];
	// writes finish in the first access cycle; reads wait one cycle so that the
	// registered read data already stands at the edge where pready is seen high
	assign pready_out  = ~rd_en | rd_wait_q;
	assign wr_en       = psel_in & penable_in & pwrite_in;
	assign rd_en       = psel_in & penable_in & ~pwrite_in;
	assign pslverr_out = psel_in & penable_in & ~hit;

	// which pins are taken away from the port by configuration
	always @* begin
		ded = {`SPIO_LINES{1'b0}};
		case (osc_mode)
			`SPIO_OSC_INT_RC: ded = {`SPIO_LINES{1'b0}}; // see [RQ9]
			`SPIO_OSC_XTAL: begin
				ded[`SPIO_BIT_OSC_IN]  = 1'b1; // see [RQ10]
				ded[`SPIO_BIT_OSC_OUT] = 1'b1;
			end
			`SPIO_OSC_RC_RTC: begin
				ded[`SPIO_BIT_OSC_IN]  = 1'b1; // see [RQ11]
				ded[`SPIO_BIT_OSC_OUT] = 1'b1;
			end
			`SPIO_OSC_EXT_RC: ded[`SPIO_BIT_OSC_IN] = 1'b1; // see [RQ12]
			default: ded = {`SPIO_LINES{1'b0}};
		endcase
		ded[`SPIO_LINES-1] = cfg_q[`SPIO_CFG_RESPIN]; // see [RQ14]
	end

	always @* begin
		case (paddr_in)
			`SPIO_OFF_DATA, `SPIO_OFF_DIR, `SPIO_OFF_PULL, `SPIO_OFF_WAKE,
			`SPIO_OFF_CFG, `SPIO_OFF_PIN, `SPIO_OFF_STAT: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	// dedicated pins read as zero
	always @* begin
		rd_pins = clean_q & ~ded; // see [RQ15]
	end

	always @* begin
		rdata_d = 32'h0000_0000;
		case (paddr_in)
			`SPIO_OFF_DATA: rdata_d[`SPIO_BIDIR-1:0]     = data_q;
			`SPIO_OFF_DIR:  rdata_d[`SPIO_BIDIR-1:0]     = dir_q;
			`SPIO_OFF_PULL: rdata_d[`SPIO_BIDIR-1:0]     = pull_q;
			`SPIO_OFF_WAKE: rdata_d[`SPIO_GEN_LINES-1:0] = wake_q;
			`SPIO_OFF_CFG:  rdata_d[5:0]                 = cfg_q;
			`SPIO_OFF_PIN:  rdata_d[`SPIO_LINES-1:0]     = rd_pins; // see [RQ1]
			`SPIO_OFF_STAT: rdata_d[`SPIO_LINES-1:0]     = ded;
			default:        rdata_d = 32'h0000_0000;
		endcase
	end

	// register writes; only byte lane 0 carries fields
	always @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			data_q <= `SPIO_RST_DATA;
			dir_q  <= `SPIO_RST_DIR;
			pull_q <= `SPIO_RST_PULL;
			wake_q <= `SPIO_RST_WAKE;
			cfg_q  <= `SPIO_RST_CFG;
			prdata_out <= 32'h0000_0000;
			rd_wait_q  <= 1'b0;
		end else begin
			rd_wait_q <= rd_en & ~rd_wait_q;
			if (rd_en && !rd_wait_q)
				prdata_out <= rdata_d;
			if (wr_en && pstrb_in[0]) begin
				case (paddr_in)
					`SPIO_OFF_DATA: data_q <= pwdata_in[`SPIO_BIDIR-1:0];
					`SPIO_OFF_DIR:  dir_q  <= pwdata_in[`SPIO_BIDIR-1:0]; // see [RQ2]
					`SPIO_OFF_PULL: pull_q <= pwdata_in[`SPIO_BIDIR-1:0]; // see [RQ4]
					`SPIO_OFF_WAKE: wake_q <= pwdata_in[`SPIO_GEN_LINES-1:0]; // see [RQ3]
					`SPIO_OFF_CFG:  cfg_q  <= pwdata_in[5:0]; // see [RQ13]
					default: begin
					end
				endcase
			end
		end
	end

	// three stage synchroniser; a change counts once stages two and three agree
	always @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s1_q    <= {`SPIO_LINES{1'b1}};
			s2_q    <= {`SPIO_LINES{1'b1}};
			s3_q    <= {`SPIO_LINES{1'b1}};
			clean_q <= {`SPIO_LINES{1'b1}};
			last_q  <= {`SPIO_LINES{1'b1}};
		end else begin
			s1_q    <= pin_in;
			s2_q    <= s1_q;
			s3_q    <= s2_q;
			clean_q <= (s2_q & s3_q) | (clean_q & (s2_q | s3_q));
			last_q  <= clean_q;
		end
	end

	// pin drive; settings of dedicated pins are ignored
	always @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pin_out         <= {`SPIO_BIDIR{1'b0}};
			pin_oe_n_out    <= {`SPIO_BIDIR{1'b1}};
			pin_pull_en_out <= {`SPIO_BIDIR{1'b0}};
		end else begin
			pin_out         <= data_q & ~ded[`SPIO_BIDIR-1:0];
			pin_oe_n_out    <= dir_q | ded[`SPIO_BIDIR-1:0]; // see [RQ2]
			pin_pull_en_out <= pull_q & ~ded[`SPIO_BIDIR-1:0]; // see [RQ4]
			if (cfg_q[`SPIO_CFG_BUZEN]) begin
				pin_out[0]      <= buzzer_drive_true_in; // see [RQ5]
				pin_out[1]      <= ~buzzer_drive_true_in; // see [RQ5]
				pin_oe_n_out[1:0] <= 2'h0;
			end
		end
	end

	// shared inputs, wake-up and configuration outputs
	always @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			counter_a_ext_input_out <= 1'b1;
			counter_b_ext_input_out <= 1'b1;
			ext_irq_n_out           <= 1'b1;
			chip_reset_n_out        <= 1'b1;
			wake_out                <= 1'b0;
			osc_mode_out            <= `SPIO_OSC_INT_RC;
			rc_freq_sel_out         <= `SPIO_FRQ_4M;
			rtc_xtal_en_out         <= 1'b0;
		end else begin
			counter_a_ext_input_out <= clean_q[`SPIO_BIT_CNT_A]; // see [RQ6]
			counter_b_ext_input_out <= clean_q[`SPIO_BIT_CNT_B]; // see [RQ7]
			ext_irq_n_out           <= clean_q[`SPIO_BIT_EXTINT]; // see [RQ8]
			// reset pin only acts when the option selects it
			chip_reset_n_out <= ~cfg_q[`SPIO_CFG_RESPIN] | clean_q[`SPIO_LINES-1]; // see [RQ14]
			// any edge on an enabled general input line wakes the core
			wake_out <= |((clean_q[`SPIO_GEN_LINES-1:0] ^ last_q[`SPIO_GEN_LINES-1:0]) & wake_q); // see [RQ3]
			osc_mode_out    <= osc_mode;
			// unused frequency code falls back to the slowest, safe at low supply
			rc_freq_sel_out <= (cfg_q[`SPIO_CFG_FRQ_HI:`SPIO_CFG_FRQ_LO] == `SPIO_FRQ_12M) ? `SPIO_FRQ_12M :
				(cfg_q[`SPIO_CFG_FRQ_HI:`SPIO_CFG_FRQ_LO] == `SPIO_FRQ_8M) ? `SPIO_FRQ_8M : `SPIO_FRQ_4M; // see [RQ13]
			rtc_xtal_en_out <= (osc_mode == `SPIO_OSC_RC_RTC); // see [RQ11]
		end
	end

endmodule // spio_port

// ### tb/spio_chk.sv
// assertion checker bound to the shared pin io port
`timescale 1ns/1ns
module spio_chk (
	input wire        clock_in, arst_n_in, psel_in, penable_in, pslverr_out,
	input wire [11:0] paddr_in,
	input wire [7:0]  pin_in,
	input wire [6:0]  pin_oe_n_out, pin_pull_en_out,
	input wire        counter_a_ext_input_out, counter_b_ext_input_out, ext_irq_n_out, chip_reset_n_out, wake_out,
	input wire [1:0]  osc_mode_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!arst_n_in);
	// six quiet cycles cover the sync and vote latency
	sequence s_q(x); (arst_n_in && $stable(x)) [*6]; endsequence
	property p_ca; s_q(pin_in[2]) |-> counter_a_ext_input_out == pin_in[2]; endproperty
	a_ca: assert property (p_ca) else $error("counter a input wrong");
	property p_cb; s_q(pin_in[4]) |-> counter_b_ext_input_out == pin_in[4]; endproperty
	a_cb: assert property (p_cb) else $error("counter b input wrong");
	property p_irq; s_q(pin_in[3]) |-> ext_irq_n_out == pin_in[3]; endproperty
	a_irq: assert property (p_irq) else $error("interrupt input wrong");
	property p_rst; s_q(pin_in[7]) |-> chip_reset_n_out || !pin_in[7]; endproperty
	a_rst: assert property (p_rst) else $error("reset out low with line high");
	property p_wk; (arst_n_in && $stable(pin_in[4:0])) [*8] |-> !wake_out; endproperty
	a_wk: assert property (p_wk) else $error("wake without change");
	property p_ded; osc_mode_out inside {2'h1, 2'h2} && $past(osc_mode_out, 2) == osc_mode_out
		|-> &pin_oe_n_out[6:5] && !pin_pull_en_out[6:5]; endproperty
	a_ded: assert property (p_ded) else $error("oscillator pins still driven");
	property p_erc; osc_mode_out == 2'h3 && $past(osc_mode_out, 2) == 2'h3
		|-> pin_oe_n_out[6] && !pin_pull_en_out[6]; endproperty
	a_erc: assert property (p_erc) else $error("rc input pin driven");
	property p_err; psel_in && penable_in && paddr_in > 12'h018 |-> pslverr_out; endproperty
	a_err: assert property (p_err) else $error("no error on unmapped access");
endmodule // spio_chk
bind spio_port spio_chk u_chk (.*);

// ### tb/spio_board.sv
// board model: each pin from device drive, outside source or pull-high
`timescale 1ns/1ns
module spio_board (
	input  wire       clock_in,
	input  wire [6:0] pin_out, pin_oe_n_out, pin_pull_en_out,
	input  wire [7:0] ext_val, ext_en,
	output wire [7:0] pin_in
);
	reg flip_q = 1'b0;
	// an undriven line wanders so a lost pull-high cannot read high by luck
	always @(posedge clock_in) flip_q <= !flip_q;
	genvar i;
	for (i = 0; i < 7; i = i + 1) begin : g_pin
		assign pin_in[i] = !pin_oe_n_out[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : pin_pull_en_out[i] | flip_q;
	end
	assign pin_in[7] = ext_en[7] ? ext_val[7] : flip_q;
endmodule // spio_board

// ### tb/tb.sv
// self-checking bench for the shared pin io port
`timescale 1ns/1ns
`include "spio_defines.vh"
module tb;
	reg clock_in = 1'b0, arst_n_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, err;
	reg buzzer_drive_true_in = 1'b0;
	reg [11:0] paddr_in = 12'h000;
	reg [31:0] pwdata_in = 32'h0, rdat;
	reg [7:0] ext_val = 8'h00, ext_en = 8'hFF;
	wire [3:0] pstrb_in = 4'hF;
	wire pready_out, pslverr_out, counter_a_ext_input_out, counter_b_ext_input_out, ext_irq_n_out;
	wire chip_reset_n_out, wake_out, rtc_xtal_en_out;
	wire [31:0] prdata_out;
	wire [7:0] pin_in;
	wire [6:0] pin_out, pin_oe_n_out, pin_pull_en_out;
	wire [1:0] osc_mode_out, rc_freq_sel_out;
	integer num_errors = 0, compares = 0, cyc = 0, i, n;
	always #20 clock_in = !clock_in;
	spio_port u_dut (.*);
	spio_board u_brd (.*);
	task chk(input [31:0] seen, input [31:0] exp, input string what);
		begin
			compares = compares + 1;
			if (seen !== exp) begin
				num_errors = num_errors + 1;
				$display("BAD %s exp %h seen %h", what, exp, seen);
			end
		end
	endtask
	// called just after a rising edge; returns just after one
	task apb(input wr, input [11:0] a, input [31:0] d);
		begin
			{psel_in, pwrite_in, paddr_in, pwdata_in} <= {1'b1, wr, a, d};
			@(posedge clock_in);
			penable_in <= 1'b1;
			@(posedge clock_in);
			while (pready_out !== 1'b1) @(posedge clock_in);
			err = pslverr_out;
			rdat = prdata_out;
			{psel_in, penable_in} <= 2'b00;
			@(posedge clock_in);
		end
	endtask
	task wrap_up;
		begin
			$display("compares %0d mismatches %0d", compares, num_errors);
			if (num_errors == 0 && compares > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	always @(posedge clock_in) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			num_errors = num_errors + 1;
			wrap_up;
		end
	end
	initial begin
		repeat (5) @(posedge clock_in);
		arst_n_in <= 1'b1;
		@(posedge clock_in);
		apb(0, `SPIO_OFF_DIR, 0);
		chk(rdat, 32'h7F, "dir");
		chk(pin_oe_n_out, 7'h7F, "oe");
		$display("test reset done");
		ext_en <= 8'hF0;
		apb(1, `SPIO_OFF_DIR, 32'h0F);
		apb(1, `SPIO_OFF_DATA, 32'h55);
		apb(1, `SPIO_OFF_PULL, 32'h0A);
		repeat (8) @(posedge clock_in);
		chk(pin_oe_n_out, 7'h0F, "oe");
		apb(0, `SPIO_OFF_PIN, 0);
		// lines 0 and 2 float and wander, so they are masked
		chk(rdat & 32'h7A, 32'h5A, "pin");
		$display("test drive done");
		ext_en <= 8'hFF;
		apb(1, `SPIO_OFF_DIR, 32'h7F);
		for (i = 0; i < 2; i = i + 1) begin
			ext_val <= i ? 8'h1B : 8'hA4;
			repeat (8) @(posedge clock_in);
			apb(0, `SPIO_OFF_PIN, 0);
			chk(rdat, ext_val, "pin");
			chk({counter_b_ext_input_out, ext_irq_n_out, counter_a_ext_input_out}, ext_val[4:2], "cnt");
			chk(chip_reset_n_out, 1'b1, "rst");
		end
		apb(1, `SPIO_OFF_WAKE, 32'h01);
		for (i = 0; i < 2; i = i + 1) begin
			ext_val <= ext_val ^ (8'h01 << i);
			n = 0;
			repeat (10) begin
				@(posedge clock_in);
				if (wake_out === 1'b1) n = n + 1;
			end
			chk(n, 1 - i, "wake");
		end
		$display("test shared done");
		ext_val <= 8'hFF;
		for (i = 0; i < 12; i = i + 1) begin
			apb(1, `SPIO_OFF_CFG, i);
			repeat (8) @(posedge clock_in);
			chk({rtc_xtal_en_out, rc_freq_sel_out, osc_mode_out}, {i % 4 == 2, i[3:0]}, "cfg");
			n = i % 4 == 3 ? 32'h40 : i % 4 ? 32'h60 : 32'h0;
			apb(0, `SPIO_OFF_STAT, 0);
			chk(rdat, n, "stat");
			apb(0, `SPIO_OFF_PIN, 0);
			chk(rdat, 32'hFF ^ n, "pin");
		end
		// the spare frequency code must fall back to the slowest setting
		apb(1, `SPIO_OFF_CFG, 32'h0C);
		repeat (8) @(posedge clock_in);
		chk(rc_freq_sel_out, 2'h0, "freq");
		$display("test osc done");
		apb(1, `SPIO_OFF_CFG, 32'h30);
		ext_val <= 8'h7F;
		buzzer_drive_true_in <= 1'b1;
		repeat (8) @(posedge clock_in);
		chk(chip_reset_n_out, 1'b0, "rst");
		chk({pin_oe_n_out[1:0], pin_out[1:0]}, 4'h1, "buz");
		apb(0, `SPIO_OFF_PIN, 0);
		chk(rdat, 32'h7D, "pin");
		buzzer_drive_true_in <= 1'b0;
		repeat (3) @(posedge clock_in);
		chk(pin_out[1:0], 2'h2, "buz");
		apb(1, 12'h0FC, 32'hFF);
		chk(err, 1'b1, "slverr");
		apb(0, 12'h0FC, 0);
		chk(rdat, 32'h0, "unmapped");
		$display("test option done");
		wrap_up;
	end
endmodule // tb
